// ### udbr_pkg.sv
package udbr_pkg;

    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int BYTE_W = 8;
    localparam int DIV_W = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_BAUD_LO = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_BAUD_HI = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_BAUD_CTRL = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_RX_STAT = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h1c;

    // baud_control_reg fields
    localparam int CTL_W = 3;
    localparam int CTL_TX_NINTH = 0;
    localparam int CTL_RX_EN = 1;
    localparam int CTL_WIDE = 2;
    localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;

    // receive status fields
    localparam int ST_W = 5;
    localparam int ST_NINTH = 0;
    localparam int ST_FRAME_ERROR_FLAG = 1;
    localparam int ST_OVERRUN_FLAG = 2;
    localparam int ST_PEND = 3;
    localparam int ST_TX_FULL = 4;

    // interrupt status / mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVERRUN_FLAG = 1;
    localparam int IRQ_TXE = 2;
    localparam int IRQ_FRAME_ERROR_FLAG = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic wide;
        logic rxEnable;
        logic txNinth;
    } udbr_ctrl_type;

    typedef struct packed {
        logic frameErr;
        logic ninth;
        logic [BYTE_W-1:0] data;
    } udbr_rx_char_type;

    typedef struct packed {
        logic ninth;
        logic [BYTE_W-1:0] data;
    } udbr_tx_char_type;

    localparam udbr_rx_char_type RX_CHAR_RESET = '{1'b0, 1'b0, 8'h00};
    localparam udbr_tx_char_type TX_CHAR_RESET = '{1'b0, 8'h00};

endpackage

// ### udbr_core.sv
// How it works
// - rx_data_holding shows low byte of oldest unread character, read-only, resets zero.
// - receive buffer holds characters with ninth bit while next one shifts in.
// - tx_data_holding is read/write, double buffered with ninth bit, resets zero.
// - baud divisor is sixteen bits in low and high byte registers, both reset zero.
// - writing baud_divisor_low restarts the baud counter at once.
// - writing baud_divisor_high restarts the baud counter at once.
// - high byte counts only when wide_divisor_select is set; else low byte alone.
// - buffer holds two; a third full character sets overrun and blocks reception.
// - rx_pending_flag is high while receiver enabled and a character unread; not writable.
// - reading rx_data_holding advances buffer; frame_error_flag follows the next character.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
module udbr_core #(
    parameter int RX_DEPTH = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [udbr_pkg::ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [udbr_pkg::DATA_W-1:0] avs_writedata, // write data
    input wire logic [udbr_pkg::BE_W-1:0] avs_byteenable, // byte lanes
    output logic [udbr_pkg::DATA_W-1:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall until answered
    input wire logic rxCharValid, // pulse: shifter finished a character
    input wire udbr_pkg::udbr_rx_char_type rxChar, // finished character
    input wire logic txTake, // pulse: shifter loads the held character
    output udbr_pkg::udbr_tx_char_type txChar, // held transmit character
    output logic txCharValid, // a character waits for the shifter
    output logic baudTick, // pulse once per divisor period
    output logic irq // level interrupt
);
    import udbr_pkg::*;

    localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ONE = 1;
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(RX_DEPTH - 1);

    if (RX_DEPTH < 2) begin : g_depthCheck
        $error("udbr_core: RX_DEPTH must be at least 2");
    end

    function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] ofs);
        regHit = (addr == ofs);
    endfunction

    function automatic logic [DIV_W-1:0] activeDivisor(input logic wide,
                                                       input logic [BYTE_W-1:0] hi,
                                                       input logic [BYTE_W-1:0] lo);
        activeDivisor = wide ? {hi, lo} : {BYTE_RESET, lo};
    endfunction

    function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] p);
        ptrInc = (p == PTR_LAST) ? PTR_ZERO : p + PTR_ONE;
    endfunction

    // bus slave state
    logic waitReq_r;
    logic [DATA_W-1:0] readData_r;
    logic [DATA_W-1:0] readData_nxt;
    logic rdAccept;
    logic wrAccept;
    logic wrLow;

    // register state
    udbr_ctrl_type ctrl_r;
    logic [BYTE_W-1:0] divLow_r;
    logic [BYTE_W-1:0] divHigh_r;
    logic [BYTE_W-1:0] divLow_nxt;
    logic [BYTE_W-1:0] divHigh_nxt;
    udbr_tx_char_type txChar_r;
    logic txFull_r;
    logic [IRQ_W-1:0] irqStat_r;
    logic [IRQ_W-1:0] irqMask_r;
    logic [IRQ_W-1:0] irqEvent;
    logic irq_r;

    // receive buffer
    udbr_rx_char_type rxMem [RX_DEPTH];
    logic [PTR_W-1:0] rdPtr_r;
    logic [PTR_W-1:0] wrPtr_r;
    logic [CNT_W-1:0] rxCount_r;
    logic overrun_r;
    logic rxPush;
    logic rxPop;
    logic popArmed_r;
    logic overrunSet;
    logic rxNotEmpty;
    logic rxPending;
    udbr_rx_char_type rxTop;

    // baud counter
    logic [DIV_W-1:0] baudCnt_r;
    logic baudTick_r;
    logic baudRestart;

    // bus handshake: answer one cycle after a request is seen
    assign rdAccept = avs_read && !waitReq_r;
    assign wrAccept = avs_write && !waitReq_r;
    assign wrLow = wrAccept && avs_byteenable[0];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            waitReq_r <= 1'b1;
        end else if ((avs_read || avs_write) && waitReq_r) begin
            waitReq_r <= 1'b0;
        end else begin
            waitReq_r <= 1'b1;
        end
    end

    // receive buffer status
    assign rxNotEmpty = (rxCount_r != CNT_ZERO);
    assign rxTop = rxMem[rdPtr_r];
    assign rxPending = ctrl_r.rxEnable && rxNotEmpty;

    always_comb begin
        readData_nxt = WORD_ZERO;
        unique case (1'b1)
            regHit(avs_address, OFS_RX_DATA): begin
                readData_nxt[BYTE_W-1:0] = rxTop.data;
            end
            regHit(avs_address, OFS_TX_DATA): begin
                readData_nxt[BYTE_W-1:0] = txChar_r.data;
            end
            regHit(avs_address, OFS_BAUD_LO): begin
                readData_nxt[BYTE_W-1:0] = divLow_r;
            end
            regHit(avs_address, OFS_BAUD_HI): begin
                readData_nxt[BYTE_W-1:0] = divHigh_r;
            end
            regHit(avs_address, OFS_BAUD_CTRL): begin
                readData_nxt[CTL_W-1:0] = ctrl_r;
            end
            regHit(avs_address, OFS_RX_STAT): begin
                readData_nxt[ST_NINTH] = rxNotEmpty && rxTop.ninth;
                readData_nxt[ST_FRAME_ERROR_FLAG] = rxNotEmpty && rxTop.frameErr;
                readData_nxt[ST_OVERRUN_FLAG] = overrun_r;
                readData_nxt[ST_PEND] = rxPending;
                readData_nxt[ST_TX_FULL] = txFull_r;
            end
            regHit(avs_address, OFS_IRQ_STAT): begin
                readData_nxt[IRQ_W-1:0] = irqStat_r;
            end
            regHit(avs_address, OFS_IRQ_MASK): begin
                readData_nxt[IRQ_W-1:0] = irqMask_r;
            end
            default: begin
                readData_nxt = WORD_ZERO;
            end
        endcase
    end

    // read data is loaded as waitrequest falls and holds through the accept edge
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readData_r <= WORD_ZERO;
        end else if (avs_read && waitReq_r) begin
            readData_r <= readData_nxt;
        end
    end

    // pop only the character that the answer carried, not one pushed meanwhile
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            popArmed_r <= 1'b0;
        end else if (avs_read && waitReq_r) begin
            popArmed_r <= regHit(avs_address, OFS_RX_DATA) && rxNotEmpty;
        end
    end

    // control register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= CTL_RESET;
        end else if (wrLow && regHit(avs_address, OFS_BAUD_CTRL)) begin
            ctrl_r <= avs_writedata[CTL_W-1:0];
        end
    end

    // divisor bytes
    always_comb begin
        divLow_nxt = divLow_r;
        divHigh_nxt = divHigh_r;
        if (wrLow && regHit(avs_address, OFS_BAUD_LO)) begin
            divLow_nxt = avs_writedata[BYTE_W-1:0];
        end
        if (wrLow && regHit(avs_address, OFS_BAUD_HI)) begin
            divHigh_nxt = avs_writedata[BYTE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            divLow_r <= BYTE_RESET;
            divHigh_r <= BYTE_RESET;
        end else begin
            divLow_r <= divLow_nxt;
            divHigh_r <= divHigh_nxt;
        end
    end

    // any write to either divisor byte restarts the count
    assign baudRestart = wrAccept && (regHit(avs_address, OFS_BAUD_LO)
                                      || regHit(avs_address, OFS_BAUD_HI));

    // down counter: divisor N gives one tick every N+1 clocks
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            baudCnt_r <= DIV_RESET;
            baudTick_r <= 1'b0;
        end else if (baudRestart) begin
            baudCnt_r <= activeDivisor(ctrl_r.wide, divHigh_nxt, divLow_nxt);
            baudTick_r <= 1'b0;
        end else if (baudCnt_r == DIV_RESET) begin
            baudCnt_r <= activeDivisor(ctrl_r.wide, divHigh_r, divLow_r);
            baudTick_r <= 1'b1;
        end else begin
            baudCnt_r <= baudCnt_r - 16'h0001;
            baudTick_r <= 1'b0;
        end
    end

    // transmit holding register: new write wins over a same-cycle take
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txChar_r <= TX_CHAR_RESET;
        end else if (wrLow && regHit(avs_address, OFS_TX_DATA)) begin
            txChar_r <= '{ctrl_r.txNinth, avs_writedata[BYTE_W-1:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txFull_r <= 1'b0;
        end else if (wrLow && regHit(avs_address, OFS_TX_DATA)) begin
            txFull_r <= 1'b1;
        end else if (txTake) begin
            txFull_r <= 1'b0;
        end
    end

    // receive buffer control
    assign rxPush = rxCharValid && ctrl_r.rxEnable && !overrun_r
                    && (rxCount_r != CNT_FULL);
    assign overrunSet = rxCharValid && ctrl_r.rxEnable && !overrun_r
                        && (rxCount_r == CNT_FULL);
    assign rxPop = rdAccept && popArmed_r;

    generate
        for (genvar i = 0; i < RX_DEPTH; i++) begin : g_rxSlot
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    rxMem[i] <= RX_CHAR_RESET;
                end else if (rxPush && (wrPtr_r == PTR_W'(i))) begin
                    rxMem[i] <= rxChar;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= PTR_ZERO;
            rdPtr_r <= PTR_ZERO;
        end else begin
            if (rxPush) begin
                wrPtr_r <= ptrInc(wrPtr_r);
            end
            if (rxPop) begin
                rdPtr_r <= ptrInc(rdPtr_r);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxCount_r <= CNT_ZERO;
        end else if (rxPush && !rxPop) begin
            rxCount_r <= rxCount_r + CNT_ONE;
        end else if (rxPop && !rxPush) begin
            rxCount_r <= rxCount_r - CNT_ONE;
        end
    end

    // overrun holds until the receiver is disabled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            overrun_r <= 1'b0;
        end else if (overrunSet) begin
            overrun_r <= 1'b1;
        end else if (!ctrl_r.rxEnable) begin
            overrun_r <= 1'b0;
        end
    end

    // interrupt status, write one to clear, set wins
    always_comb begin
        irqEvent = IRQ_RESET;
        irqEvent[IRQ_RX] = rxPush;
        irqEvent[IRQ_OVERRUN_FLAG] = overrunSet;
        irqEvent[IRQ_TXE] = txTake && txFull_r;
        irqEvent[IRQ_FRAME_ERROR_FLAG] = rxPush && rxChar.frameErr;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStat_r <= IRQ_RESET;
        end else if (wrLow && regHit(avs_address, OFS_IRQ_STAT)) begin
            irqStat_r <= (irqStat_r & ~avs_writedata[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStat_r <= irqStat_r | irqEvent;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqMask_r <= IRQ_RESET;
        end else if (wrLow && regHit(avs_address, OFS_IRQ_MASK)) begin
            irqMask_r <= avs_writedata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irqStat_r & irqMask_r);
        end
    end

    assign avs_waitrequest = waitReq_r;
    assign avs_readdata = readData_r;
    assign txChar = txChar_r;
    assign txCharValid = txFull_r;
    assign baudTick = baudTick_r;
    assign irq = irq_r;

endmodule

// ### udbr_core_sva.sv
module udbr_core_sva #(
    parameter int RX_DEPTH = 2
) (
    input wire logic clk_sys, // clock
    input wire logic reset_n, // reset
    input wire logic [udbr_pkg::ADDR_W-1:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [udbr_pkg::DATA_W-1:0] avs_writedata, // write data
    input wire logic [udbr_pkg::BE_W-1:0] avs_byteenable, // lanes
    input wire logic [udbr_pkg::DATA_W-1:0] avs_readdata, // read data
    input wire logic avs_waitrequest, // stall
    input wire logic rxCharValid, // rx pulse
    input wire udbr_pkg::udbr_rx_char_type rxChar, // rx char
    input wire logic txTake, // tx load
    input wire udbr_pkg::udbr_tx_char_type txChar, // tx char
    input wire logic txCharValid, // tx held
    input wire logic baudTick, // tick
    input wire logic irq // interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    import udbr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence acc(logic [ADDR_W-1:0] a);
        avs_write && !avs_waitrequest && avs_address == a;
    endsequence
    sequence rdAcc;
        avs_read && !avs_waitrequest;
    endsequence
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    answer_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    read_width_a: assert property (rdAcc |-> avs_readdata[DATA_W-1:BYTE_W] == '0)
        else $error("read data above byte not zero");
    low_restart_a: assert property (acc(OFS_BAUD_LO) |=> !baudTick)
        else $error("tick right after low divisor write");
    high_restart_a: assert property (acc(OFS_BAUD_HI) |=> !baudTick)
        else $error("tick right after high divisor write");
    tx_load_a: assert property (acc(OFS_TX_DATA) ##0 avs_byteenable[0]
        |=> txCharValid && txChar.data == $past(avs_writedata[BYTE_W-1:0]))
        else $error("tx character not loaded");
    tx_take_a: assert property (txTake && txCharValid && !avs_write |=> !txCharValid)
        else $error("tx character not released");
    tx_hold_a: assert property (txCharValid && !txTake && !avs_write
        |=> txCharValid && $stable(txChar))
        else $error("held tx character changed");
endmodule

bind udbr_core udbr_core_sva #(.RX_DEPTH(RX_DEPTH)) udbr_core_sva_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxCharValid(rxCharValid), .rxChar(rxChar),
    .txTake(txTake), .txChar(txChar), .txCharValid(txCharValid), .baudTick(baudTick),
    .irq(irq));

// ### udbr_shifter_model.sv
module udbr_shifter_model (
    input wire logic clk_sys, // clock
    input wire logic reset_n, // reset
    input wire logic sendReq, // bench asks for a finished character
    input wire udbr_pkg::udbr_rx_char_type sendChar, // character to deliver
    input wire logic [3:0] takeDelay, // wait before loading
    input wire logic txCharValid, // design holds a character
    output udbr_pkg::udbr_rx_char_type rxChar, // finished character
    output logic rxCharValid, // finished pulse
    output logic txTake // shifter loads
);
    timeunit 1ns;
    timeprecision 1ps;
    import udbr_pkg::*;
    logic [3:0] waitCnt;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxCharValid <= 1'b0;
            rxChar <= RX_CHAR_RESET;
        end else begin
            rxCharValid <= sendReq;
            // outside a pulse the lines change every cycle
            rxChar <= sendReq ? sendChar : ~rxChar;
        end
    end
    // load only a held character, after a chosen stall
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            waitCnt <= 4'h0;
            txTake <= 1'b0;
        end else begin
            txTake <= txCharValid && !txTake && waitCnt == takeDelay;
            waitCnt <= (txCharValid && !txTake && waitCnt != takeDelay) ? waitCnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ### uart_data_and_baud_registers_test.sv
module uart_data_and_baud_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    import udbr_pkg::*;
    logic clk_sys = 0, reset_n = 0, avs_read = 0, avs_write = 0, sendReq = 0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, q;
    logic [BE_W-1:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, rxCharValid, txTake, txCharValid, baudTick, irq, rxEn = 0, ovr = 0;
    udbr_rx_char_type rxChar, sendChar = '0;
    udbr_tx_char_type txChar;
    logic [3:0] takeDelay = 4'h2;
    logic [9:0] rxQ[$];
    logic [8:0] txQ[$];
    int n_mismatch = 0, compares = 0, d;
    initial forever #2.5 clk_sys = ~clk_sys;
    udbr_core udbr_core_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxCharValid(rxCharValid), .rxChar(rxChar),
        .txTake(txTake), .txChar(txChar), .txCharValid(txCharValid), .baudTick(baudTick),
        .irq(irq));
    udbr_shifter_model udbr_shifter_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
        .sendReq(sendReq), .sendChar(sendChar), .takeDelay(takeDelay),
        .txCharValid(txCharValid), .rxChar(rxChar), .rxCharValid(rxCharValid), .txTake(txTake));
    task automatic chk(input logic [DATA_W-1:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        bus(1'b0, a, '0);
        chk(q, exp);
    endtask
    task automatic chkIrq(input logic exp);
        @(negedge clk_sys);
        chk(irq, exp);
        @(posedge clk_sys);
    endtask
    task automatic period(input int exp);
        int n;
        while (baudTick !== 1'b1) @(posedge clk_sys);
        @(posedge clk_sys);
        for (n = 1; baudTick !== 1'b1; n++) @(posedge clk_sys);
        chk(n, exp);
    endtask
    task automatic send(input int k);
        logic [9:0] c;
        repeat (k) begin
            c = 10'($urandom_range(1023, 0));
            sendReq <= 1'b1;
            sendChar <= c;
            if (rxEn && !ovr) begin
                if (rxQ.size() < 2) rxQ.push_back(c);
                else ovr = 1'b1;
            end
            @(posedge clk_sys);
        end
        sendReq <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic pop;
        logic [9:0] c;
        c = rxQ.size() > 0 ? rxQ[0] : 10'h0;
        rd(OFS_RX_STAT, {28'h0, rxEn && rxQ.size() > 0, ovr, c[9], c[8]});
        if (rxQ.size() > 0 && rxEn) begin
            rd(OFS_RX_DATA, c[7:0]);
            void'(rxQ.pop_front());
        end
    endtask
    task automatic setRx(input logic en);
        rxEn = en;
        if (!en) ovr = 1'b0;
        bus(1'b1, OFS_BAUD_CTRL, 32'(en) << CTL_RX_EN);
    endtask
    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys)
        if (txTake === 1'b1 && txQ.size() > 0) chk(txChar, txQ.pop_front());
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        stop_test;
    end
    initial begin
        d = $urandom(37);
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_RX_DATA, 0);
        rd(OFS_TX_DATA, 0);
        rd(OFS_BAUD_LO, 0);
        rd(OFS_BAUD_HI, 0);
        bus(1'b1, OFS_RX_DATA, 32'h0000_00a5);
        rd(OFS_RX_DATA, 32'h0);
        $display("reset test done");
        d = $urandom_range(9, 2);
        bus(1'b1, OFS_BAUD_LO, d);
        rd(OFS_BAUD_LO, d);
        bus(1'b1, OFS_BAUD_HI, 32'h1);
        rd(OFS_BAUD_HI, 32'h1);
        period(d + 1);
        bus(1'b1, OFS_BAUD_CTRL, 1 << CTL_WIDE);
        // restart so that no period measured still runs on the narrow divisor
        bus(1'b1, OFS_BAUD_LO, d);
        period(257 + d);
        $display("baud test done");
        bus(1'b1, OFS_IRQ_MASK, 1 << IRQ_RX);
        setRx(1'b1);
        send(3);
        chkIrq(1'b1);
        pop;
        pop;
        pop;
        send(1);
        pop;
        setRx(1'b0);
        send(1);
        pop;
        setRx(1'b1);
        send(1);
        setRx(1'b0);
        pop;
        setRx(1'b1);
        pop;
        bus(1'b1, OFS_IRQ_STAT, 32'hf);
        chkIrq(1'b0);
        $display("receive test done");
        for (int i = 0; i < 4; i++) begin
            d = $urandom_range(255, 0);
            takeDelay <= 4'($urandom_range(15, 0));
            bus(1'b1, OFS_BAUD_CTRL, i & 1);
            bus(1'b1, OFS_TX_DATA, d);
            txQ.push_back({i[0], d[7:0]});
            rd(OFS_TX_DATA, d);
            while (txQ.size() > 0) @(posedge clk_sys);
        end
        rd(OFS_IRQ_STAT, 1 << IRQ_TXE);
        chkIrq(1'b0);
        bus(1'b1, OFS_IRQ_MASK, 1 << IRQ_TXE);
        chkIrq(1'b1);
        bus(1'b1, OFS_IRQ_STAT, 1 << IRQ_TXE);
        chkIrq(1'b0);
        $display("transmit test done");
        stop_test;
    end
endmodule
